// *** logic/eag_core.sv ***
// Instruction decoder and start-address generator with status and bus slave
module eag_core
    import eag_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Avalon-MM slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    output logic irq_o,
    // Instruction and sequencer handshake
    input wire logic instr_load_i,
    input wire logic [15:0] m_side_bus_i,
    input wire logic seq_take_i,
    input wire logic seq_end_i,
    output logic seq_valid_o,
    output eag_seq_t sequence_start_address_o,
    output logic emu_done_o,
    // Interrupt priority logic
    input wire logic irq_req_i,
    input wire logic vector_enable_i,
    input wire logic [2:0] irq_level_i,
    // Flag update path
    input wire logic fetch_issued_i,
    input wire logic flag_fw_en_i,
    input wire logic [3:0] alu_flags_i,
    // A-operand bus
    input wire logic a_sel_i,
    input wire logic [3:0] a_field_i,
    output logic [15:0] a_operand_bus_o
);
    typedef enum logic [2:0] {ST_IDLE, ST_OPER1, ST_OPER2, ST_EXEC, ST_VECT} eag_state_t;

    function automatic eag_class_t instr_class(input logic [15:0] ir);
        unique case (ir[15:14])
            2'b00: instr_class = CL_CTRL;
            2'b01: instr_class = CL_SINGLE;
            default: instr_class = CL_DOUBLE;
        endcase
    endfunction

    // Variable selector: which bits address the execute table
    function automatic logic [5:0] exec_key(input logic [15:0] ir);
        unique case (instr_class(ir))
            CL_DOUBLE: exec_key = {2'b10, ir[15:12]};
            CL_SINGLE: exec_key = {2'b01, ir[9:6]};
            default: exec_key = {2'b00, ir[3:0]};
        endcase
    endfunction

    // Execute ROM contents as a constant function of the key
    function automatic eag_exec_word_t exec_rom(input logic [5:0] key);
        eag_exec_word_t w;
        w.start = {1'b0, key, 1'b0};
        w.special = 4'h0;
        unique case (key[5:4])
            2'b10: begin
                w.flag_ctl = ALL_FLAGS;
                w.special[SP_SKIP_OP2] = (key[3:0] == 4'h1);
            end
            2'b01: w.flag_ctl = NZV_FLAGS;
            default: begin
                w.flag_ctl = key[3:0];
                w.special[SP_NO_FLAGS] = (key[3:0] == 4'h0);
                w.special[SP_HALT] = (key[3:0] == 4'h1);
            end
        endcase
        exec_rom = w;
    endfunction

    // Operand table: slot 0 source, slot 1 destination
    function automatic logic [7:0] opnd_rom(input logic slot, input logic [2:0] mode);
        opnd_rom = {OPND_BASE, slot, mode, 2'b00};
    endfunction

    eag_state_t state_reg;
    logic issued_reg;
    logic [15:0] emulated_instruction_reg;
    eag_exec_word_t exec_word;
    eag_class_t cls;
    eag_seq_t seq_reg;
    logic done_reg;
    logic [15:0] emulated_status_word;
    logic [3:0] flag_ctl_reg;
    logic flag_pend_reg;
    logic [15:0] microstatus_reg;
    logic [15:0] a_bus_reg;
    logic [1:0] ctrl_reg;
    logic [EV_W-1:0] int_status_reg;
    logic [EV_W-1:0] int_enable_reg;
    logic [EV_W-1:0] events;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic wr_fire;
    logic halt_reg;
    logic go_vect;
    logic go_instr;

    assign exec_word = exec_rom(exec_key(emulated_instruction_reg)); // RULE_07
    assign cls = instr_class(emulated_instruction_reg); // RULE_01
    assign go_vect = irq_req_i && vector_enable_i; // RULE_03
    assign go_instr = instr_load_i && ctrl_reg[CTRL_DECODE_EN] && !halt_reg;

    // Avalon slave: one wait cycle on every access
    assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
    assign wr_fire = avs_write_i && ack_reg;
    assign avs_readdata_o = rdata_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 32'h0;
        end else if (avs_read_i && !ack_reg) begin
            unique case (avs_address_i)
                REG_CTRL: rdata_reg <= {30'h0, ctrl_reg};
                REG_STATUS_WORD: rdata_reg <= {16'h0, emulated_status_word}; // RULE_13
                REG_INSTR: rdata_reg <= {16'h0, emulated_instruction_reg};
                REG_MICROSTATUS: rdata_reg <= {16'h0, microstatus_reg};
                REG_INT_STATUS: rdata_reg <= {29'h0, int_status_reg};
                REG_INT_ENABLE: rdata_reg <= {29'h0, int_enable_reg};
                default: rdata_reg <= 32'h0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ctrl_reg <= CTRL_RESET;
            int_enable_reg <= '0;
        end else if (wr_fire) begin
            if (avs_address_i == REG_CTRL) begin
                ctrl_reg <= avs_writedata_i[1:0];
            end
            if (avs_address_i == REG_INT_ENABLE) begin
                int_enable_reg <= avs_writedata_i[EV_W-1:0];
            end
        end
    end

    // Sticky events; a new event outranks a same-cycle clear
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            int_status_reg <= '0;
        end else if (wr_fire && avs_address_i == REG_INT_CLEAR) begin
            int_status_reg <= (int_status_reg & ~avs_writedata_i[EV_W-1:0]) | events;
        end else begin
            int_status_reg <= int_status_reg | events;
        end
    end

    assign irq_o = |(int_status_reg & int_enable_reg);

    // Sequencing of operand, execution and vector sequences
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            issued_reg <= 1'b0;
            emulated_instruction_reg <= 16'h0;
        end else begin
            if (seq_valid_o && seq_take_i) begin
                issued_reg <= 1'b1;
            end
            unique case (state_reg)
                ST_IDLE: begin
                    issued_reg <= 1'b0;
                    // Interrupts are taken only between instructions
                    if (go_vect) begin
                        state_reg <= ST_VECT; // RULE_03
                    end else if (go_instr) begin
                        emulated_instruction_reg <= m_side_bus_i;
                        unique case (instr_class(m_side_bus_i)) // RULE_04
                            CL_CTRL: state_reg <= ST_EXEC;
                            default: state_reg <= ST_OPER1;
                        endcase
                    end
                end
                ST_OPER1: if (issued_reg && seq_end_i) begin
                    issued_reg <= 1'b0;
                    if (cls == CL_DOUBLE && !exec_word.special[SP_SKIP_OP2]) begin
                        state_reg <= ST_OPER2; // RULE_04
                    end else begin
                        state_reg <= ST_EXEC; // RULE_09
                    end
                end
                ST_OPER2: if (issued_reg && seq_end_i) begin
                    issued_reg <= 1'b0;
                    state_reg <= ST_EXEC;
                end
                ST_EXEC, ST_VECT: if (issued_reg && seq_end_i) begin
                    issued_reg <= 1'b0;
                    state_reg <= ST_IDLE; // RULE_06
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    assign seq_valid_o = (state_reg != ST_IDLE) && !issued_reg;

    // Start address per state from the matching table
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            seq_reg <= '{kind: SK_EXEC, start: 8'h0};
        end else begin
            unique case (state_reg)
                ST_OPER1: seq_reg <= '{kind: SK_OPND, start: opnd_rom(cls == CL_SINGLE,
                    cls == CL_SINGLE ? emulated_instruction_reg[5:3] : emulated_instruction_reg[11:9])}; // RULE_05
                ST_OPER2: seq_reg <= '{kind: SK_OPND, start: opnd_rom(1'b1, emulated_instruction_reg[5:3])}; // RULE_05
                ST_EXEC: seq_reg <= '{kind: SK_EXEC, start: exec_word.start}; // RULE_08
                ST_VECT: seq_reg <= seq_reg;
                default: if (go_vect) begin
                    seq_reg <= '{kind: SK_VECT, start: {VEC_BASE, irq_level_i}}; // RULE_02
                end
            endcase
        end
    end

    // Address is registered, so each state spends one settle cycle
    logic settle_reg;
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            settle_reg <= 1'b0;
        end else begin
            settle_reg <= seq_valid_o;
        end
    end
    assign sequence_start_address_o = seq_reg;

    // Completion pulse and halt on special control bit
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            done_reg <= 1'b0;
            halt_reg <= 1'b0;
        end else begin
            done_reg <= (state_reg == ST_EXEC) && issued_reg && seq_end_i; // RULE_06
            // Halt event outranks a same-cycle control write, so no halt is lost
            if (state_reg == ST_EXEC && issued_reg && seq_end_i && exec_word.special[SP_HALT]) begin
                halt_reg <= 1'b1; // RULE_09
            end else if (wr_fire && avs_address_i == REG_CTRL) begin
                halt_reg <= 1'b0;
            end
        end
    end
    assign emu_done_o = done_reg;

    assign events[EV_DONE] = done_reg;
    assign events[EV_VECTOR] = (state_reg == ST_VECT) && issued_reg && seq_end_i;
    assign events[EV_HALT] = (state_reg == ST_EXEC) && issued_reg && seq_end_i && exec_word.special[SP_HALT];

    // Flag control is armed at execution end and applied after next fetch
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            flag_ctl_reg <= 4'h0;
            flag_pend_reg <= 1'b0;
        end else if (state_reg == ST_EXEC && issued_reg && seq_end_i) begin
            flag_ctl_reg <= exec_word.special[SP_NO_FLAGS] ? 4'h0 : exec_word.flag_ctl; // RULE_10
            flag_pend_reg <= 1'b1;
        end else if (fetch_issued_i) begin
            flag_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            emulated_status_word <= STATUS_WORD_RESET;
        end else begin
            if (wr_fire && avs_address_i == REG_STATUS_WORD) begin
                emulated_status_word <= avs_writedata_i[15:0];
            end
            // Hardware flag update wins over a bus write on the bits of 3:0 selected by flag_ctl_reg
            if (fetch_issued_i && flag_pend_reg && flag_fw_en_i) begin // RULE_12
                for (int i = FLAG_C; i <= FLAG_N; i++) begin // RULE_11
                    if (flag_ctl_reg[i]) begin
                        emulated_status_word[i] <= alu_flags_i[i]; // RULE_10
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            microstatus_reg <= 16'h0;
        end else begin
            microstatus_reg <= {4'h0, exec_word.special, 1'b0, halt_reg, flag_pend_reg,
                issued_reg, cls, state_reg == ST_IDLE, state_reg == ST_VECT};
        end
    end

    // Operand bus multiplexer selected by the A-operand field
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            a_bus_reg <= 16'h0;
        end else if (a_sel_i) begin
            unique case (a_field_i) // RULE_16
                AF_INSTR: a_bus_reg <= emulated_instruction_reg; // RULE_14
                AF_STATUS: a_bus_reg <= emulated_status_word; // RULE_13
                AF_MICRO: a_bus_reg <= microstatus_reg; // RULE_15
                default: a_bus_reg <= 16'h0;
            endcase
        end else begin
            a_bus_reg <= 16'h0;
        end
    end
    assign a_operand_bus_o = a_bus_reg;

    a_wait_one: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("waitrequest held longer than one cycle");
    a_vector_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_03
        (state_reg == ST_IDLE) ##1 (state_reg == ST_VECT) |-> $past(go_vect))
        else $error("vector sequence without enable");
    a_vector_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_02
        (state_reg == ST_IDLE && go_vect) |=> seq_reg.kind == SK_VECT && seq_reg.start[2:0] == $past(irq_level_i))
        else $error("vector address mismatch");
    a_double_two: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_04
        (state_reg == ST_OPER1 && issued_reg && seq_end_i && cls == CL_DOUBLE && !exec_word.special[SP_SKIP_OP2])
        |=> state_reg == ST_OPER2)
        else $error("double operand skipped second fetch");
    a_ctrl_exec: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_04
        (state_reg == ST_IDLE && !go_vect && go_instr && m_side_bus_i[15:14] == 2'b00) |=> state_reg == ST_EXEC)
        else $error("control instruction fetched operands");
    a_done_exec: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_06
        emu_done_o |-> $past(state_reg == ST_EXEC) && state_reg == ST_IDLE)
        else $error("completion without execution sequence");
    a_exec_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_08
        (state_reg == ST_EXEC && settle_reg && seq_valid_o) |-> seq_reg.start == exec_word.start)
        else $error("execution address not from table");
    a_op_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_05
        (state_reg == ST_OPER2 && settle_reg && seq_valid_o) |-> seq_reg.kind == SK_OPND)
        else $error("operand sequence kind wrong");
    // Same-cycle bus write alters the unselected flag bits
    a_flag_update: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_10
        (fetch_issued_i && flag_pend_reg && flag_fw_en_i && !(wr_fire && avs_address_i == REG_STATUS_WORD))
        |=> emulated_status_word[3:0] ==
        (($past(alu_flags_i) & $past(flag_ctl_reg)) | ($past(emulated_status_word[3:0]) & ~$past(flag_ctl_reg))))
        else $error("flag update wrong");
    a_flag_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_12
        !(fetch_issued_i && flag_pend_reg) && !(wr_fire && avs_address_i == REG_STATUS_WORD)
        |=> $stable(emulated_status_word[3:0]))
        else $error("flags changed outside update cycle");
    a_abus_instr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_14
        (a_sel_i && a_field_i == AF_INSTR) |=> a_operand_bus_o == $past(emulated_instruction_reg))
        else $error("operand bus not instruction");
    // Sticky status: an enabled event raises the interrupt on the next cycle
    a_irq_level: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        |(events & int_enable_reg) && !(wr_fire && avs_address_i == REG_INT_ENABLE) |=> irq_o)
        else $error("enabled event did not raise interrupt");
    a_halt_wins: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_09
        events[EV_HALT] |=> halt_reg)
        else $error("halt lost to control write");

    c_double_done: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        state_reg == ST_OPER2 ##[1:50] emu_done_o);
    c_vector: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        events[EV_VECTOR]);
    c_flags: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        fetch_issued_i && flag_pend_reg && flag_fw_en_i && flag_ctl_reg != 4'h0);
    c_halt: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        events[EV_HALT]);
    c_int_clear: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_fire && avs_address_i == REG_INT_CLEAR && |int_status_reg);
endmodule

// *** shared/eag_pkg.sv ***
// Constants, types and table contents of the emulation address generator
// Contract
// [RULE_01] Partly decode instructions, supply start addresses
// [RULE_02] Operand, execute and interrupt-vector address tables
// [RULE_03] Vector address only when priority logic enables
// [RULE_04] Double: two operands; single: one; control: none
// [RULE_05] One operand sequence fetches one operand
// [RULE_06] Execution sequence always; its end completes emulation
// [RULE_07] Execute ROM gives 16-bit word per key
// [RULE_08] Eight word bits form execution start address
// [RULE_09] Four word bits steer internal special functions
// [RULE_10] Top four bits gate status flag updates
// [RULE_11] Status bits: 3 negative, 2 zero, 1 overflow, 0 carry
// [RULE_12] Flags update right after next fetch issued
// [RULE_13] Status word readable on register bus and operand bus
// [RULE_14] Instruction and microstatus readable on operand bus
// [RULE_15] Operand-field address selects operand bus source
// [RULE_16] Field codes and special bit layout chosen here
package eag_pkg;
    // Register byte addresses
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_STATUS_WORD = 5'h04;
    localparam logic [4:0] REG_INSTR = 5'h08;
    localparam logic [4:0] REG_MICROSTATUS = 5'h0c;
    localparam logic [4:0] REG_INT_STATUS = 5'h10;
    localparam logic [4:0] REG_INT_CLEAR = 5'h14;
    localparam logic [4:0] REG_INT_ENABLE = 5'h18;
    // Control register fields and reset value
    localparam int CTRL_DECODE_EN = 0;
    localparam logic [1:0] CTRL_RESET = 2'h1;
    localparam logic [15:0] STATUS_WORD_RESET = 16'h0000;
    // Status flag positions
    localparam int FLAG_N = 3;
    localparam int FLAG_Z = 2;
    localparam int FLAG_V = 1;
    localparam int FLAG_C = 0;
    // Event bits
    localparam int EV_DONE = 0;
    localparam int EV_VECTOR = 1;
    localparam int EV_HALT = 2;
    localparam int EV_W = 3;
    // Operand-bus source codes in the A-operand field
    localparam logic [3:0] AF_INSTR = 4'h1;
    localparam logic [3:0] AF_STATUS = 4'h2;
    localparam logic [3:0] AF_MICRO = 4'h3;
    // Special control bit positions in the execute word
    localparam int SP_SKIP_OP2 = 0;
    localparam int SP_NO_FLAGS = 2;
    localparam int SP_HALT = 3;
    // Table address bases and flag-control masks
    localparam logic [1:0] OPND_BASE = 2'h2;
    localparam logic [4:0] VEC_BASE = 5'h18;
    localparam logic [3:0] ALL_FLAGS = 4'hf;
    localparam logic [3:0] NZV_FLAGS = 4'he;

    typedef enum logic [1:0] {CL_CTRL, CL_SINGLE, CL_DOUBLE} eag_class_t;
    typedef enum logic [1:0] {SK_OPND, SK_EXEC, SK_VECT} eag_kind_t;

    typedef struct packed {
        logic [3:0] flag_ctl;
        logic [3:0] special;
        logic [7:0] start;
    } eag_exec_word_t;

    typedef struct packed {
        eag_kind_t kind;
        logic [7:0] start;
    } eag_seq_t;
endpackage

// *** tb/eag_seq_model.sv ***
// Sequencer model: takes offered start addresses and ends each sequence
module eag_seq_model
    import eag_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Offer from the generator, and latency set by the bench
    input wire logic seq_valid_i,
    input wire eag_seq_t seq_addr_i,
    input wire logic [3:0] lat_i,
    // Sequencer answers
    output logic seq_take_o,
    output logic seq_end_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic seen_reg;
    logic [3:0] wait_reg;
    logic [9:0] log [$];

    // Take only in a later offer cycle; the address settles one edge after valid
    always @(posedge clk_i) begin
        seq_take_o <= 1'b0;
        seq_end_o <= 1'b0;
        if (!rst_n_i) begin
            seen_reg <= 1'b0;
            wait_reg <= 4'h0;
        end else if (seq_take_o) begin
            log.push_back(seq_addr_i);
            seen_reg <= 1'b0;
            wait_reg <= lat_i;
        end else if (wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
            seq_end_o <= (wait_reg == 4'h1);
        end else if (seq_valid_i) begin
            seen_reg <= 1'b1;
            seq_take_o <= seen_reg;
        end
    end
endmodule

// *** tb/emulation_address_generator_test.sv ***
// Self-checking bench for the emulation address generator
module emulation_address_generator_test
    import eag_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] PROG [6] = '{16'ha6d8, 16'h4a68, 16'h0006, 16'h0000, 16'hc040, 16'h8000};
    localparam logic [3:0] FLG [6] = '{4'ha, 4'h5, 4'hf, 4'hf, 4'h3, 4'h9};
    logic clk_i = 1'b0, rst_n_i = 1'b0;
    logic [4:0] avs_address_i = 5'h00;
    logic avs_read_i = 1'b0, avs_write_i = 1'b0, instr_load_i = 1'b0, seq_take_i, seq_end_i;
    logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o;
    logic avs_waitrequest_o, irq_o, seq_valid_o, emu_done_o;
    logic [15:0] m_side_bus_i = 16'h0, a_operand_bus_o, sw = 16'h0;
    logic irq_req_i = 1'b0, vector_enable_i = 1'b0, fetch_issued_i = 1'b0, flag_fw_en_i = 1'b0, a_sel_i = 1'b0;
    logic [2:0] irq_level_i = 3'h0;
    logic [3:0] alu_flags_i = 4'h0, a_field_i = 4'h0, lat = 4'h1, fctl = 4'h0;
    eag_seq_t sequence_start_address_o;
    int fail_count = 0, comparisons = 0;

    eag_core uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
        .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o), .instr_load_i(instr_load_i),
        .m_side_bus_i(m_side_bus_i), .seq_take_i(seq_take_i), .seq_end_i(seq_end_i), .seq_valid_o(seq_valid_o),
        .sequence_start_address_o(sequence_start_address_o), .emu_done_o(emu_done_o), .irq_req_i(irq_req_i),
        .vector_enable_i(vector_enable_i), .irq_level_i(irq_level_i), .fetch_issued_i(fetch_issued_i),
        .flag_fw_en_i(flag_fw_en_i), .alu_flags_i(alu_flags_i), .a_sel_i(a_sel_i), .a_field_i(a_field_i),
        .a_operand_bus_o(a_operand_bus_o));
    eag_seq_model model (.clk_i(clk_i), .rst_n_i(rst_n_i), .seq_valid_i(seq_valid_o),
        .seq_addr_i(sequence_start_address_o), .lat_i(lat), .seq_take_o(seq_take_i), .seq_end_o(seq_end_i));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= wr;
        avs_read_i <= !wr;
        do begin
            @(posedge clk_i);
        end while (avs_waitrequest_o !== 1'b0);
        q = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic a_read(input logic [3:0] f, output logic [31:0] q);
        a_sel_i <= 1'b1;
        a_field_i <= f;
        @(posedge clk_i);
        a_sel_i <= 1'b0;
        @(posedge clk_i);
        q = {16'h0, a_operand_bus_o};
    endtask

    task automatic run_instr(input logic [15:0] ir);
        logic [9:0] e [$];
        logic [5:0] key;
        logic [31:0] q;
        int n;
        n = 0;
        model.log.delete();
        if (ir[15]) begin
            key = {2'b10, ir[15:12]};
            fctl = ALL_FLAGS;
            e.push_back({SK_OPND, OPND_BASE, 1'b0, ir[11:9], 2'b00});
        end else if (ir[14]) begin
            key = {2'b01, ir[9:6]};
            fctl = NZV_FLAGS;
        end else begin
            key = {2'b00, ir[3:0]};
            fctl = ir[3:0];
        end
        if (ir[15:14] != 2'b00) e.push_back({SK_OPND, OPND_BASE, 1'b1, ir[5:3], 2'b00});
        e.push_back({SK_EXEC, 1'b0, key, 1'b0});
        instr_load_i <= 1'b1;
        m_side_bus_i <= ir;
        @(posedge clk_i);
        instr_load_i <= 1'b0;
        while (emu_done_o !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        check(n < 300, 32'h1);
        check(model.log.size(), e.size());
        foreach (e[i]) check(model.log[i], e[i]);
        a_read(AF_INSTR, q);
        check(q, {16'h0, ir});
    endtask

    // Status read starts in the cycle after the fetch edge, so a late update shows
    task automatic flag_step(input logic [3:0] fl, input logic fw);
        logic [31:0] q;
        fetch_issued_i <= 1'b1;
        flag_fw_en_i <= fw;
        alu_flags_i <= fl;
        @(posedge clk_i);
        fetch_issued_i <= 1'b0;
        if (fw) sw[3:0] = (sw[3:0] & ~fctl) | (fl & fctl);
        a_read(AF_STATUS, q);
        check(q, {16'h0, sw});
        bus(1'b0, REG_STATUS_WORD, 32'h0, q);
        check(q, {16'h0, sw});
    endtask

    task automatic load_refused(input logic [15:0] ir);
        model.log.delete();
        instr_load_i <= 1'b1;
        m_side_bus_i <= ir;
        @(posedge clk_i);
        instr_load_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        check(model.log.size(), 32'h0);
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        tally_and_finish();
    end

    initial begin
        logic [31:0] q;
        int n;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        @(posedge clk_i);
        bus(1'b0, REG_CTRL, 32'h0, q);
        check(q, {30'h0, CTRL_RESET});
        bus(1'b0, 5'h1c, 32'h0, q);
        check(q, 32'h0);
        a_read(4'h0, q);
        check(q, 32'h0);
        bus(1'b1, REG_STATUS_WORD, 32'h1230, q);
        sw = 16'h1230;
        foreach (PROG[i]) begin
            run_instr(PROG[i]);
            flag_step(FLG[i], i != 5);
        end
        bus(1'b1, REG_CTRL, 32'h0, q);
        load_refused(16'h0005);
        bus(1'b1, REG_CTRL, 32'h1, q);
        run_instr(16'h0001);
        bus(1'b0, REG_INT_STATUS, 32'h0, q);
        check(q[EV_HALT], 1'b1);
        a_read(AF_MICRO, q);
        check({q[6], q[1]}, 2'b11);
        load_refused(16'h0005);
        bus(1'b1, REG_CTRL, 32'h1, q);
        run_instr(16'h0005);
        // Slow sequencer for the vector path
        lat <= 4'h6;
        bus(1'b1, REG_INT_ENABLE, 32'h2, q);
        model.log.delete();
        irq_level_i <= 3'h5;
        irq_req_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        check(seq_valid_o, 1'b0);
        vector_enable_i <= 1'b1;
        n = 0;
        while (model.log.size() == 0 && n < 100) begin
            @(posedge clk_i);
            n++;
        end
        irq_req_i <= 1'b0;
        vector_enable_i <= 1'b0;
        check(model.log[0], {SK_VECT, VEC_BASE, 3'h5});
        n = 0;
        do begin
            bus(1'b0, REG_INT_STATUS, 32'h0, q);
            n++;
        end while (q[EV_VECTOR] !== 1'b1 && n < 20);
        check(model.log.size(), 32'h1);
        check(irq_o, 1'b1);
        bus(1'b1, REG_INT_ENABLE, 32'h0, q);
        check(irq_o, 1'b0);
        bus(1'b1, REG_INT_CLEAR, 32'h2, q);
        bus(1'b1, REG_INT_ENABLE, 32'h2, q);
        check(irq_o, 1'b0);
        bus(1'b0, REG_INT_STATUS, 32'h0, q);
        check(q[EV_VECTOR], 1'b0);
        tally_and_finish();
    end
endmodule
